/* File: pkg/scr_pkg.sv */
`default_nettype none
package scr_pkg;

  // register map, one aligned word each
  localparam logic [7:0] CLK_CFG_OFS    = 8'h00;
  localparam logic [7:0] GATE_OFS       = 8'h04;
  localparam logic [7:0] REG_CTRL_OFS   = 8'h08;
  localparam logic [7:0] RST_CAUSE_OFS  = 8'h0C;

  // field positions in run_mode_clock_config
  localparam int OSC_SRC_LSB   = 4;
  localparam int CRYSTAL_VALUE_FIELD_LSB      = 6;
  localparam int BYPASS_BIT    = 11;
  localparam int PWM_DIV_LSB   = 17;
  localparam int SYSTEM_CLOCK_DIVISOR_FIELD_LSB    = 23;

  // oscillator source codes
  typedef enum logic [1:0] {
    SCR_SRC_MAIN  = 2'h0,
    SCR_SRC_INT   = 2'h1,
    SCR_SRC_INT4  = 2'h2,
    SCR_SRC_RSVD  = 2'h3
  } scr_osc_e;

  // run_mode_clock_config contents
  typedef struct packed {
    logic [3:0] system_clock_divisor_field;  // divide by field plus one
    logic [2:0] pwm_clock_divisor;     // pwm ratio is two to the (code+1)
    logic       bypass;                // high: oscillator drives divider
    logic [3:0] crystal_value_field;   // crystal number
    scr_osc_e   osc_source_select;     // oscillator pick
  } scr_rcc_s;

  // translated settings handed to the pll
  typedef struct packed {
    logic       load;                  // one-cycle update strobe
    scr_osc_e   ref_src;               // reference oscillator
    logic [3:0] crystal;               // crystal number in use
  } scr_pll_cfg_s;

  // reset values
  localparam logic [3:0] SYSTEM_CLOCK_DIVISOR_FIELD_RST    = 4'hF;
  localparam logic [2:0] PWM_CLOCK_DIVISOR_RST    = 3'h0;
  localparam logic       BYPASS_RST    = 1'b1;
  localparam logic [3:0] CRYSTAL_VALUE_FIELD_RST      = 4'h0;

  // divisor limits
  localparam logic [3:0] PLL_MIN_CODE  = 4'h3;
  localparam logic [4:0] BYPASS_MIN_DIV = 5'h02;
  localparam logic [1:0] INT4_LAST     = 2'h3;

  // timing: clock, converter target and internal reset hold
  localparam int CLK_KHZ       = 200000;
  localparam int ADC_KHZ       = 16670;
  // rounded to nearest; plain truncation would give a ratio one short
  localparam int ADC_DIV       = (CLK_KHZ + ADC_KHZ / 2) / ADC_KHZ;
  localparam int RST_HOLD_NS   = 100;
  localparam int RST_HOLD_CYC  = (RST_HOLD_NS * CLK_KHZ + 999999) / 1000000;

  // cause bits
  localparam int CAUSE_REG_BIT = 0;
  localparam int CAUSE_WDT_BIT = 1;

endpackage
`default_nettype wire

/* File: logic/scr_tick_div.sv */
`timescale 1ns/10ps
`default_nettype none
// divides a stream of ticks by div; new ratio taken only at a period boundary
module scr_tick_div #(
  parameter int            W       = 5,
  parameter logic [W-1:0]  DIV_RST = '1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // input events and ratio
  input  wire logic         tick,
  input  wire logic [W-1:0] div,
  // divided clock level and its rising event
  output var  logic         clk_q,
  output var  logic         rise_q
);

  logic [W-1:0] cnt_q;    // ticks into current period
  logic [W-1:0] div_q;    // ratio of current period
  logic         wrap;     // last tick of the period
  logic [W-1:0] cnt_d;
  logic [W:0]   half_d;   // high phase length of next state

  // latching the ratio at wrap is what keeps runts off the output
  always_comb
  begin
    wrap   = (cnt_q >= div_q - W'(1));
    cnt_d  = wrap ? '0 : cnt_q + W'(1);
    half_d = wrap ? ({1'b0, div} + (W+1)'(1)) >> 1 : ({1'b0, div_q} + (W+1)'(1)) >> 1;
  end

  // period counter and ratio latch
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // parked on the last count so the first tick starts a full period
      cnt_q <= DIV_RST - W'(1);
      div_q <= DIV_RST;
    end
    else if (tick)
    begin
      cnt_q <= cnt_d;
      if (wrap)
        div_q <= div;
    end
  end

  // output level and rise event
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      clk_q  <= 1'b0;
      rise_q <= 1'b0;
    end
    else
    begin
      rise_q <= tick & wrap;
      if (tick)
        clk_q <= ({1'b0, cnt_d} < half_d);
    end
  end

endmodule
`default_nettype wire

/* File: logic/scr_rst_seq.sv */
`timescale 1ns/10ps
`default_nettype none
// asserts the internal reset for a fixed hold, then releases it
module scr_rst_seq #(
  parameter int HOLD = 20
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // reset request pulse
  input  wire logic req,
  // internal reset, low active
  output var  logic int_rst_b_q
);

  typedef enum logic [1:0] {
    SCR_RS_IDLE = 2'b01,
    SCR_RS_HOLD = 2'b10
  } scr_rs_e;

  scr_rs_e     state_q;
  logic [15:0] cnt_q;   // cycles spent in hold

  // requests during hold are absorbed; the hold is not restarted
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q     <= SCR_RS_IDLE;
      cnt_q       <= '0;
      int_rst_b_q <= 1'b1;
    end
    else
    begin
      case (state_q)
        SCR_RS_IDLE:
        begin
          cnt_q <= '0;
          if (req)
          begin
            state_q     <= SCR_RS_HOLD;
            int_rst_b_q <= 1'b0;
          end
        end
        SCR_RS_HOLD:
        begin
          cnt_q <= cnt_q + 16'h0001;
          if (cnt_q >= 16'(HOLD - 1))
          begin
            state_q     <= SCR_RS_IDLE;
            int_rst_b_q <= 1'b1;
          end
        end
        default:
        begin
          state_q     <= SCR_RS_IDLE;
          int_rst_b_q <= 1'b1;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

/* File: logic/scr_clk_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module scr_clk_ctrl #(
  parameter int NUM_PERIPH = 8,
  parameter int RST_HOLD   = scr_pkg::RST_HOLD_CYC
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  // register port
  input  wire logic [7:0]            addr,
  input  wire logic [31:0]           wdata,
  input  wire logic                  wr,
  input  wire logic                  rd,
  output var  logic [31:0]           rdata_q,
  // oscillator, pll and regulator pins, asynchronous
  input  wire logic                  main_osc_in,
  input  wire logic                  int_osc_in,
  input  wire logic                  pll_out_in,
  input  wire logic                  reg_unregulated,
  // watchdog events, same clock
  input  wire logic                  wdog_timeout,
  input  wire logic                  wdog_int_clear,
  input  wire logic                  wdog_reset_en,
  // derived clocks
  output var  logic                  sys_clk_q,
  output var  logic                  adc_clk_q,
  output var  logic                  pwm_clk_q,
  output var  logic [NUM_PERIPH-1:0] periph_clk_q,
  // pll reference and settings
  output var  logic                  pll_ref_q,
  output var  scr_pkg::scr_pll_cfg_s pll_cfg_q,
  // internal reset, low active
  output var  logic                  int_rst_b_q
);

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  localparam int NPIN = 4;
  logic [NPIN-1:0] s1_q;       // first stage, read only by s2
  logic [NPIN-1:0] s2_q;
  logic [NPIN-1:0] s3_q;
  logic [NPIN-1:0] lvl_q;      // accepted level
  logic [NPIN-1:0] rise;       // accepted rising change
  logic [NPIN-1:0] pins;

  assign pins = {reg_unregulated, pll_out_in, int_osc_in, main_osc_in};

  // a change counts only once stages two and three agree
  generate
    for (genvar i = 0; i < NPIN; i++)
    begin : g_sync
      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          s1_q[i]  <= 1'b0;
          s2_q[i]  <= 1'b0;
          s3_q[i]  <= 1'b0;
          lvl_q[i] <= 1'b0;
        end
        else
        begin
          s1_q[i] <= pins[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
          if (s2_q[i] == s3_q[i])
            lvl_q[i] <= s3_q[i];
        end
      end
      assign rise[i] = (s2_q[i] == s3_q[i]) & s3_q[i] & ~lvl_q[i];
    end
  endgenerate

  logic main_rise;
  logic internal_oscillator_rise;
  logic pll_rise;
  logic unreg_rise;
  assign main_rise  = rise[0];
  assign internal_oscillator_rise  = rise[1];
  assign pll_rise   = rise[2];
  assign unreg_rise = rise[3];

  //////////////////////////////////////////////////////////////////////////////
  // registers
  scr_pkg::scr_rcc_s     rcc_q;            // run_mode_clock_config
  logic [NUM_PERIPH-1:0] gate_q;           // peripheral gate enables
  logic                  reg_rst_en_q;     // regulator_control reset enable
  logic                  reg_fault_q;      // regulator_fault_reset flag
  logic                  wdt_cause_q;      // watchdog reset flag
  logic                  wdt_first_q;      // first timeout pending
  logic                  wr_rcc;
  logic                  wr_cause;

  assign wr_rcc   = wr & (addr == scr_pkg::CLK_CFG_OFS);
  assign wr_cause = wr & (addr == scr_pkg::RST_CAUSE_OFS);

  // configuration writes
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rcc_q.system_clock_divisor_field <= scr_pkg::SYSTEM_CLOCK_DIVISOR_FIELD_RST;
      rcc_q.pwm_clock_divisor    <= scr_pkg::PWM_CLOCK_DIVISOR_RST;
      rcc_q.bypass               <= scr_pkg::BYPASS_RST;
      rcc_q.crystal_value_field  <= scr_pkg::CRYSTAL_VALUE_FIELD_RST;
      rcc_q.osc_source_select    <= scr_pkg::SCR_SRC_MAIN;
      gate_q                     <= '0;
      reg_rst_en_q               <= 1'b0;
    end
    else if (wr)
    begin
      if (addr == scr_pkg::CLK_CFG_OFS)
      begin
        rcc_q.osc_source_select    <= scr_pkg::scr_osc_e'(wdata[scr_pkg::OSC_SRC_LSB +: 2]);
        rcc_q.crystal_value_field  <= wdata[scr_pkg::CRYSTAL_VALUE_FIELD_LSB +: 4];
        rcc_q.bypass               <= wdata[scr_pkg::BYPASS_BIT];
        rcc_q.pwm_clock_divisor    <= wdata[scr_pkg::PWM_DIV_LSB +: 3];
        rcc_q.system_clock_divisor_field <= wdata[scr_pkg::SYSTEM_CLOCK_DIVISOR_FIELD_LSB +: 4];
      end
      else if (addr == scr_pkg::GATE_OFS)
        gate_q <= wdata[NUM_PERIPH-1:0];
      else if (addr == scr_pkg::REG_CTRL_OFS)
        reg_rst_en_q <= wdata[0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // reset sources
  logic wdt_req;
  logic reg_req;

  assign wdt_req = wdog_timeout & wdt_first_q & wdog_reset_en;
  assign reg_req = unreg_rise & reg_rst_en_q;

  // first timeout flag; a new timeout wins over the interrupt clear
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      wdt_first_q <= 1'b0;
    else if (wdog_timeout)
      wdt_first_q <= ~wdt_req;
    else if (wdog_int_clear)
      wdt_first_q <= 1'b0;
  end

  // sticky cause flags, write one to clear, set wins
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg_fault_q <= 1'b0;
      wdt_cause_q <= 1'b0;
    end
    else
    begin
      if (reg_req)
        reg_fault_q <= 1'b1;
      else if (wr_cause & wdata[scr_pkg::CAUSE_REG_BIT])
        reg_fault_q <= 1'b0;
      if (wdt_req)
        wdt_cause_q <= 1'b1;
      else if (wr_cause & wdata[scr_pkg::CAUSE_WDT_BIT])
        wdt_cause_q <= 1'b0;
    end
  end

  // both sources share one sequencer; it leaves this block's state alone
  scr_rst_seq #(
    .HOLD        (RST_HOLD)
  ) u_rst (
    .clk         (clk),
    .rst_b       (rst_b),
    .req         (wdt_req | reg_req),
    .int_rst_b_q (int_rst_b_q)
  );

  //////////////////////////////////////////////////////////////////////////////
  // source selection
  logic [1:0] int4_cnt_q;   // internal oscillator quarter count
  logic       int4_tick;
  logic       src_tick;
  logic       src_lvl;
  logic       sys_in_tick;

  assign int4_tick = internal_oscillator_rise & (int4_cnt_q == scr_pkg::INT4_LAST);

  // internal oscillator divided by four
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      int4_cnt_q <= '0;
    else if (internal_oscillator_rise)
      int4_cnt_q <= int4_cnt_q + 2'h1;
  end

  // oscillator mux; the reserved code falls back to the internal oscillator
  always_comb
  begin
    case (rcc_q.osc_source_select)
      scr_pkg::SCR_SRC_MAIN:
      begin
        src_tick = main_rise;
        src_lvl  = lvl_q[0];
      end
      scr_pkg::SCR_SRC_INT4:
      begin
        src_tick = int4_tick;
        src_lvl  = int4_cnt_q[1];
      end
      default:
      begin
        src_tick = internal_oscillator_rise;
        src_lvl  = lvl_q[1];
      end
    endcase
    sys_in_tick = rcc_q.bypass ? src_tick : pll_rise;
  end

  // pll reference follows the picked oscillator
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      pll_ref_q <= 1'b0;
    else
      pll_ref_q <= src_lvl;
  end

  //////////////////////////////////////////////////////////////////////////////
  // pll settings from the crystal number
  scr_pkg::scr_rcc_s rcc_prev_q;

  // rewriting the same crystal does not reload the pll
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rcc_prev_q <= '0;
      pll_cfg_q  <= '0;
    end
    else
    begin
      rcc_prev_q      <= rcc_q;
      pll_cfg_q.load  <= ~rcc_q.bypass & (rcc_q.crystal_value_field != rcc_prev_q.crystal_value_field
                         | rcc_q.osc_source_select != rcc_prev_q.osc_source_select
                         | rcc_prev_q.bypass);
      if (!rcc_q.bypass)
      begin
        pll_cfg_q.crystal <= rcc_q.crystal_value_field;
        pll_cfg_q.ref_src <= rcc_q.osc_source_select;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // system divider
  logic [4:0] sys_div;
  logic       sys_rise_q;

  // reserved pll codes are clamped to divide by four as a safety net
  always_comb
  begin
    sys_div = {1'b0, rcc_q.system_clock_divisor_field} + 5'h01;
    if (rcc_q.bypass && sys_div < scr_pkg::BYPASS_MIN_DIV)
      sys_div = scr_pkg::BYPASS_MIN_DIV;
    else if (!rcc_q.bypass && rcc_q.system_clock_divisor_field < scr_pkg::PLL_MIN_CODE)
      sys_div = {1'b0, scr_pkg::PLL_MIN_CODE} + 5'h01;
  end

  scr_tick_div #(
    .W       (5),
    .DIV_RST ({1'b0, scr_pkg::SYSTEM_CLOCK_DIVISOR_FIELD_RST} + 5'h01)
  ) u_sys (
    .clk     (clk),
    .rst_b   (rst_b),
    .tick    (sys_in_tick),
    .div     (sys_div),
    .clk_q   (sys_clk_q),
    .rise_q  (sys_rise_q)
  );

  //////////////////////////////////////////////////////////////////////////////
  // converter and pwm clocks
  localparam logic [3:0] ADC_N = 4'(scr_pkg::ADC_DIV);
  logic [8:0] pwm_div;      // wide enough for the largest ratio of 256

  // fixed ratio from the core clock, nothing for software to set
  scr_tick_div #(
    .W       (4),
    .DIV_RST (ADC_N)
  ) u_adc (
    .clk     (clk),
    .rst_b   (rst_b),
    .tick    (1'b1),
    .div     (ADC_N),
    .clk_q   (adc_clk_q),
    .rise_q  ()
  );

  assign pwm_div = 9'h002 << rcc_q.pwm_clock_divisor;

  // counts system clock rises, so it stays in step with the system clock
  scr_tick_div #(
    .W       (9),
    .DIV_RST (9'h002)
  ) u_pwm (
    .clk     (clk),
    .rst_b   (rst_b),
    .tick    (sys_rise_q),
    .div     (pwm_div),
    .clk_q   (pwm_clk_q),
    .rise_q  ()
  );

  //////////////////////////////////////////////////////////////////////////////
  // peripheral gates; a delayed copy of the system clock keeps phase aligned
  generate
    for (genvar p = 0; p < NUM_PERIPH; p++)
    begin : g_gate
      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
          periph_clk_q[p] <= 1'b0;
        else if (!sys_clk_q)
          periph_clk_q[p] <= 1'b0;
        else if (gate_q[p])
          periph_clk_q[p] <= 1'b1;
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // read port, data one cycle after the strobe
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rdata_q <= '0;
    else if (rd)
    begin
      rdata_q <= '0;
      if (addr == scr_pkg::CLK_CFG_OFS)
      begin
        rdata_q[scr_pkg::OSC_SRC_LSB +: 2] <= rcc_q.osc_source_select;
        rdata_q[scr_pkg::CRYSTAL_VALUE_FIELD_LSB +: 4]    <= rcc_q.crystal_value_field;
        rdata_q[scr_pkg::BYPASS_BIT]       <= rcc_q.bypass;
        rdata_q[scr_pkg::PWM_DIV_LSB +: 3] <= rcc_q.pwm_clock_divisor;
        rdata_q[scr_pkg::SYSTEM_CLOCK_DIVISOR_FIELD_LSB +: 4]  <= rcc_q.system_clock_divisor_field;
      end
      else if (addr == scr_pkg::GATE_OFS)
        rdata_q[NUM_PERIPH-1:0] <= gate_q;
      else if (addr == scr_pkg::REG_CTRL_OFS)
        rdata_q[0] <= reg_rst_en_q;
      else if (addr == scr_pkg::RST_CAUSE_OFS)
      begin
        rdata_q[scr_pkg::CAUSE_REG_BIT] <= reg_fault_q;
        rdata_q[scr_pkg::CAUSE_WDT_BIT] <= wdt_cause_q;
      end
    end
    else
      rdata_q <= '0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  localparam int ADC_P  = scr_pkg::ADC_DIV;
  localparam int HOLD_M = RST_HOLD + 1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_wdt_reset: assert property (wdt_req |=> !int_rst_b_q || !$past(int_rst_b_q))
    else $error("watchdog second timeout gave no reset");
  chk_reg_gated: assert property (!reg_rst_en_q |-> !reg_req)
    else $error("regulator reset while disabled");
  chk_reg_flag: assert property (reg_req |=> reg_fault_q && (!int_rst_b_q || !$past(int_rst_b_q)))
    else $error("regulator fault flag or reset missing");
  chk_rst_release: assert property ($fell(int_rst_b_q) |-> !int_rst_b_q[*2] ##[1:HOLD_M] int_rst_b_q)
    else $error("internal reset not released in time");
  chk_src_path: assert property (rcc_q.bypass && rcc_q.osc_source_select == scr_pkg::SCR_SRC_MAIN
                                 |-> sys_in_tick == main_rise)
    else $error("main oscillator not routed");
  chk_pll_path: assert property (!rcc_q.bypass |-> sys_in_tick == pll_rise)
    else $error("pll output not routed");
  chk_pll_clamp: assert property (!rcc_q.bypass |-> sys_div >= 5'h04)
    else $error("reserved divisor reached pll path");
  chk_adc_period: assert property ($rose(adc_clk_q) |-> ##[ADC_P:ADC_P] $rose(adc_clk_q))
    else $error("converter clock period wrong");
  chk_gate_off: assert property (!gate_q[0] && !periph_clk_q[0] |=> !periph_clk_q[0])
    else $error("gated peripheral clock toggled");
  chk_set_wins: assert property (reg_req && wr_cause |=> reg_fault_q)
    else $error("fault flag lost to clear");

  cov_wdt_reset: cover property (wdt_req ##1 !int_rst_b_q);
  cov_reg_reset: cover property (reg_req ##1 reg_fault_q);
  cov_pll_sys: cover property (!rcc_q.bypass && sys_rise_q);
  cov_cfg_write: cover property (wr_rcc ##2 pll_cfg_q.load);

endmodule
`default_nettype wire

/* File: sim/scr_clk_ctrl_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module scr_clk_ctrl_tb;
  // short internal reset hold keeps the run brief
  localparam int HOLD = 6;
  logic                  clk, rst_b, wr, rd;           // clock, reset and strobes
  logic [7:0]            addr;                         // register address
  logic [31:0]           wdata, rdata_q, rv;           // bus data and last read value
  logic                  main_oscillator, internal_oscillator, pll, unreg;       // oscillator pins and regulator flag
  logic                  wto, wclr, wen;               // watchdog events
  logic                  sys_clk_q, adc_clk_q, pwm_clk_q, pll_ref_q, int_rst_b_q;
  logic [7:0]            periph_clk_q, seen, m;        // gated clocks and their activity
  scr_pkg::scr_pll_cfg_s pll_cfg_q;                    // pll settings
  logic [31:0]           seed;                         // xorshift state
  logic [3:0]            x;                            // random crystal number
  logic                  sp;                           // last sys clock level
  int                    errors, num_checks, per, lows, runt, run, tick;

  scr_clk_ctrl #(.NUM_PERIPH(8), .RST_HOLD(HOLD)) u_dut (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q),
    .main_osc_in(main_oscillator), .int_osc_in(internal_oscillator), .pll_out_in(pll), .reg_unregulated(unreg),
    .wdog_timeout(wto), .wdog_int_clear(wclr), .wdog_reset_en(wen),
    .sys_clk_q(sys_clk_q), .adc_clk_q(adc_clk_q), .pwm_clk_q(pwm_clk_q), .periph_clk_q(periph_clk_q),
    .pll_ref_q(pll_ref_q), .pll_cfg_q(pll_cfg_q), .int_rst_b_q(int_rst_b_q));

  //////////////////////////////////////////////////////////////////////////////
  // clock generator
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // oscillator pins: main period 6, internal period 4, pll period 10 clocks
  always @(posedge clk)
  begin
    tick <= tick + 1;
    main_oscillator <= (tick % 6) < 3;
    internal_oscillator <= (tick % 4) < 2;
    pll  <= (tick % 10) < 5;
  end

  // runt watch: no sys clock phase may be shorter than two clocks
  always @(posedge clk)
  begin
    #1;
    if (rst_b !== 1'b1)
      run = 9;
    else if (sys_clk_q !== sp)
    begin
      if (run < 2) runt++;
      run = 1;
    end
    else
      run++;
    sp = sys_clk_q;
  end

  //////////////////////////////////////////////////////////////////////////////
  // expectation helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // configuration word from its fields
  function automatic logic [31:0] cfg(logic [1:0] s, logic [3:0] xt, logic b, logic [2:0] p, logic [3:0] d);
    return (32'(s) << scr_pkg::OSC_SRC_LSB) | (32'(xt) << scr_pkg::CRYSTAL_VALUE_FIELD_LSB) | (32'(b) << scr_pkg::BYPASS_BIT)
         | (32'(p) << scr_pkg::PWM_DIV_LSB) | (32'(d) << scr_pkg::SYSTEM_CLOCK_DIVISOR_FIELD_LSB);
  endfunction

  // system divide ratio; reserved pll codes clamp to four, bypass code zero halves
  function automatic int sys_n(logic b, logic [3:0] d);
    if (!b && d < 4'h3) return 4;
    if (d == 4'h0) return 2;
    return int'(d) + 1;
  endfunction

  function automatic logic sig(int w);
    return (w == 0) ? sys_clk_q : (w == 1) ? adc_clk_q : pwm_clk_q;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // bus, compare and measurement tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 rv = rdata_q;
  endtask

  // period in clocks between the second and third rise; bounded wait
  task automatic meas(input int w);
    int i, n, t;
    logic p, s;
    n = 0; t = 0; p = 1'b1; per = 0;
    for (i = 0; i < 3000 && n < 3; i++)
    begin
      @(posedge clk);
      #1 s = sig(w);
      if (s && !p)
      begin
        n++;
        if (n == 2) t = i;
        if (n == 3) per = i - t;
      end
      p = s;
    end
    if (n < 3)
    begin
      errors++;
      stop_test();
    end
  endtask

  // one-cycle watchdog event: timeout or first-timeout clear
  task automatic wd(input logic c);
    @(posedge clk);
    if (c) wclr <= 1'b1;
    else wto <= 1'b1;
    @(posedge clk);
    wto <= 1'b0; wclr <= 1'b0;
  endtask

  // count cycles of internal reset over a fixed window
  task automatic watch();
    lows = 0;
    repeat (30)
    begin
      #1 if (int_rst_b_q === 1'b0) lows++;
      @(posedge clk);
    end
  endtask

  task automatic stop_test();
    $display("errors=%0d checks=%0d", errors, num_checks);
    if (errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    rst_b = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 32'h0; unreg = 1'b0; wto = 1'b0;
    wclr = 1'b0; wen = 1'b0; main_oscillator = 1'b0; internal_oscillator = 1'b0; pll = 1'b0; tick = 0; runt = 0; run = 9;
    sp = 1'b0; seed = 32'h0000E159; errors = 0; num_checks = 0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    rd_reg(scr_pkg::CLK_CFG_OFS); chk(rv, cfg(2'h0, 4'h0, 1'b1, 3'h0, 4'hF));
    rd_reg(scr_pkg::GATE_OFS); chk(rv, 32'h0);
    rd_reg(scr_pkg::REG_CTRL_OFS); chk(rv, 32'h0);
    rd_reg(8'h40); chk(rv, 32'h0);
    meas(0); meas(0); chk(32'(per), 32'h60);
    meas(1); chk(32'(per), 32'h0C);
    // bypass divide codes, a random one then corner codes two, one and zero
    foreach (x[i])
    begin
      m = (i == 3) ? 8'(xs()) : 8'(i);
      wr_reg(scr_pkg::CLK_CFG_OFS, cfg(2'h0, 4'h0, 1'b1, 3'h0, m[3:0]));
      meas(0); meas(0); chk(32'(per), 32'(sys_n(1'b1, m[3:0]) * 6));
    end
    // internal, internal by four, and code three as internal
    for (int s = 1; s < 4; s++)
    begin
      wr_reg(scr_pkg::CLK_CFG_OFS, cfg(2'(s), 4'h0, 1'b1, 3'h0, 4'h3));
      meas(0); meas(0); chk(32'(per), 32'((s == 2) ? 64 : 16));
    end
    // pll path including reserved code one
    for (int d = 0; d < 6; d += 2)
    begin
      wr_reg(scr_pkg::CLK_CFG_OFS, cfg(2'h0, 4'h0, 1'b0, 3'h0, 4'(d + 1)));
      meas(0); meas(0); chk(32'(per), 32'(sys_n(1'b0, 4'(d + 1)) * 10));
    end
    x = 4'(xs());
    wr_reg(scr_pkg::CLK_CFG_OFS, cfg(2'h1, x, 1'b0, 3'h0, 4'h5));
    @(posedge clk) #1 chk(32'(pll_cfg_q.load), 32'h1);
    repeat (3) @(posedge clk);
    #1 chk(32'({pll_cfg_q.ref_src, pll_cfg_q.crystal}), 32'({2'h1, x}));
    // the same crystal written again must not reload the pll
    wr_reg(scr_pkg::CLK_CFG_OFS, cfg(2'h1, x, 1'b0, 3'h0, 4'h5));
    @(posedge clk) #1 chk(32'(pll_cfg_q.load), 32'h0);
    // pwm ratio on a twelve-clock system clock
    for (int p = 0; p < 3; p += 2)
    begin
      wr_reg(scr_pkg::CLK_CFG_OFS, cfg(2'h0, 4'h0, 1'b1, 3'(p), 4'h1));
      meas(2); meas(2); chk(32'(per), 32'(12 << (p + 1)));
    end
    // independent gates
    m = 8'(xs());
    wr_reg(scr_pkg::GATE_OFS, 32'(m));
    rd_reg(scr_pkg::GATE_OFS); chk(rv, 32'(m));
    seen = 8'h00;
    repeat (60) @(posedge clk) #1 seen = seen | periph_clk_q;
    chk(32'(seen), 32'(m));
    // watchdog: disabled, then serviced, then second unserviced timeout
    wd(1'b0); wd(1'b0); watch(); chk(32'(lows), 32'h0);
    wd(1'b1);
    @(posedge clk) wen <= 1'b1;
    wd(1'b0); wd(1'b1); wd(1'b0); watch(); chk(32'(lows), 32'h0);
    wd(1'b0); watch(); chk(32'(lows), 32'(HOLD));
    rd_reg(scr_pkg::RST_CAUSE_OFS); chk(rv, 32'h2);
    wr_reg(scr_pkg::RST_CAUSE_OFS, 32'h2);
    rd_reg(scr_pkg::RST_CAUSE_OFS); chk(rv, 32'h0);
    // regulator loss, first with its reset off
    @(posedge clk) unreg <= 1'b1;
    watch(); chk(32'(lows), 32'h0);
    rd_reg(scr_pkg::RST_CAUSE_OFS); chk(rv, 32'h0);
    @(posedge clk) unreg <= 1'b0;
    wr_reg(scr_pkg::REG_CTRL_OFS, 32'h1);
    repeat (6) @(posedge clk);
    unreg <= 1'b1;
    watch(); chk(32'(lows), 32'(HOLD));
    rd_reg(scr_pkg::RST_CAUSE_OFS); chk(rv, 32'h1);
    chk(32'(runt), 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire
